// ### rtl/link_timing_defines.svh
// Purpose: Shared constants for the link-timing and alignment ends.
// Assumes: One clock at 20 MHz standing in for the frame clock.
// Notes:   Fractional alignment delays are held in eighths of a frame.
`ifndef LINK_TIMING_DEFINES_SVH
`define LINK_TIMING_DEFINES_SVH

`define CLK_PERIOD_NS        50
`define SYSREF_HIGH_MIN      3'h2
`define SYSREF_LOW_MIN       3'h2
`define SYNC_HOLD_MIN        3'h4
`define ILA_MULTIFRAMES      3'h4
`define K_MIN                6'h09
`define K_MAX                6'h20
`define K_RESET              6'h20
`define LMFC_DLY_DIV1_8TH    6'h1C
`define LMFC_DLY_DIV2_8TH    6'h20
`define LMFC_DLY_DIV4_8TH    6'h1E
`define LMFC_DLY_DIV8_8TH    6'h1D
`define OUT_DLY_FRAMES       4'h7
`define OUT_DLY_MAX          4'h9
`define GAP_TIME_NS          5
`define GAP_CYCLES           ((`GAP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DIV_1                2'h0
`define DIV_2                2'h1
`define DIV_4                2'h2
`define DIV_8                2'h3
`define K28_5                8'hBC
`define ILA_START            8'h1C
`define ILA_END              8'h7C
`define FIFO_DEPTH           8

`endif

// ### rtl/link_timing_pkg.sv
// Purpose: Types shared by both ends.
// Assumes: Nothing beyond the defines header.
// Notes:   Gray codes along comma, wait, alignment, data.
package link_timing_pkg;
  typedef enum logic [1:0] {
    ST_COMMA = 2'h0,
    ST_WAIT  = 2'h1,
    ST_ILA   = 2'h3,
    ST_DATA  = 2'h2
  } tx_state_e;
  typedef logic [15:0] frame_t;
endpackage

// ### rtl/link_timing_if.sv
// Purpose: Link between transmitter and receiver ends.
// Assumes: Single clock; frames move whole, one per cycle.
// Notes:   ctl_k marks a control-character frame.
interface link_timing_if;
  logic                      sysref;
  logic                      sync_n;
  link_timing_pkg::frame_t   lane_data;
  logic                      lane_ctl_k;
  logic                      lane_valid;
  logic                      spi_select_low;
  modport tx (input sysref, input sync_n, input spi_select_low,
              output lane_data, output lane_ctl_k, output lane_valid);
  modport rx (output sysref, output sync_n, output spi_select_low,
              input lane_data, input lane_ctl_k, input lane_valid);
endinterface

// ### rtl/sample_fifo.sv
// Purpose: Sample buffer in front of the serial lane.
// Assumes: Synchronous reset, shared clock enable.
// Notes:   Depth must be a power of two.
module sample_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  wire              full_w  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  wire              empty_w = (wr_q == rd_q);
  wire              push_w  = in_valid && !full_w;
  wire              pop_w   = out_ready && !empty_w;

  assign in_ready  = !full_w;
  assign out_valid = !empty_w;
  assign out_data  = mem[rd_q[AW-1:0]];

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else if (clk_en) begin
      if (push_w) begin
        mem[wr_q[AW-1:0]] <= in_data;
        wr_q              <= wr_q + 1'b1;
      end
      if (pop_w) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule // sample_fifo

// ### rtl/link_tx_end.sv
// Purpose: Transmitter end: SYSREF alignment, LMFC, comma, ILA and data.
// Assumes: One clock cycle stands for one frame clock cycle.
// Notes:   Fractional alignment delays round up to whole frames.
`include "link_timing_defines.svh"

module link_tx_end (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  link_timing_if.tx        lnk,
  input  wire logic [1:0]  input_clock_divide_ratio,
  input  wire logic [5:0]  frames_per_multiframe,
  input  wire logic        sysref_gate_en,
  input  wire logic [15:0] sample_data,
  input  wire logic        sample_valid,
  output logic             sample_ready,
  output logic             lmfc_pulse_q,
  output logic             aligned_q,
  output logic             link_up_q
);
  // ****************************************************************
  // Configuration and SYSREF capture
  // ****************************************************************
  function automatic logic [5:0] align_eighths(input logic [1:0] div);
    case (div)
      `DIV_1:  align_eighths = `LMFC_DLY_DIV1_8TH;
      `DIV_2:  align_eighths = `LMFC_DLY_DIV2_8TH;
      `DIV_4:  align_eighths = `LMFC_DLY_DIV4_8TH;
      default: align_eighths = `LMFC_DLY_DIV8_8TH;
    endcase
  endfunction

  logic [1:0]  div_q;
  logic [5:0]  k_q;
  logic        sysref_q;
  logic [3:0]  align_cnt_q;
  logic        align_run_q;
  logic [5:0]  frame_q;
  link_timing_pkg::tx_state_e state_q;
  logic [3:0]  pipe_cnt_q;
  logic [2:0]  mf_cnt_q;
  logic [5:0]  ila_frame_q;

  wire       div_change_w = (input_clock_divide_ratio != div_q);
  wire [5:0] k_clamped_w  = (frames_per_multiframe < `K_MIN) ? `K_MIN :
                            (frames_per_multiframe > `K_MAX) ? `K_MAX : frames_per_multiframe;
  wire       sysref_rise_w = sysref_gate_en && lnk.sysref && !sysref_q;
  wire [5:0] dly_frames_w  = (align_eighths(div_q) + 6'h07) >> 3;
  wire       lmfc_w        = (frame_q == k_q - 6'h01);
  wire       restart_w     = div_change_w || !lnk.sync_n;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      div_q    <= `DIV_1;
      k_q      <= `K_RESET;
      sysref_q <= 1'b0;
    end else if (clk_en) begin
      div_q    <= input_clock_divide_ratio;
      sysref_q <= lnk.sysref;
      if (state_q == link_timing_pkg::ST_COMMA) begin
        k_q <= k_clamped_w;
      end
    end
  end

  // ****************************************************************
  // Local multiframe clock
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      frame_q     <= '0;
      align_cnt_q <= '0;
      align_run_q <= 1'b0;
      aligned_q   <= 1'b0;
      lmfc_pulse_q <= 1'b0;
    end else if (clk_en) begin
      lmfc_pulse_q <= lmfc_w;
      frame_q      <= lmfc_w ? 6'h00 : frame_q + 6'h01;
      if (sysref_rise_w) begin
        align_run_q <= 1'b1;
        align_cnt_q <= dly_frames_w[3:0] - 4'h1;
      end else if (align_run_q) begin
        if (align_cnt_q == 4'h0) begin
          // The boundary lands on the edge at which the count runs out
          align_run_q  <= 1'b0;
          aligned_q    <= 1'b1;
          frame_q      <= 6'h00;
          lmfc_pulse_q <= 1'b1;
        end else begin
          align_cnt_q <= align_cnt_q - 4'h1;
        end
      end
      // A new ratio voids the old alignment; SYSREF must come again
      if (div_change_w) begin
        aligned_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Link state machine
  // ****************************************************************
  // A fixed pipeline of seven frames after the LMFC keeps both the ILA
  // and the data start inside their window without tracking each separately.
  wire pipe_done_w = (pipe_cnt_q == `OUT_DLY_FRAMES - 4'h1);
  logic [15:0] out_data_w;
  logic        out_k_w;
  logic        fifo_pop_w;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_q     <= link_timing_pkg::ST_COMMA;
      pipe_cnt_q  <= '0;
      mf_cnt_q    <= '0;
      ila_frame_q <= '0;
      link_up_q   <= 1'b0;
    end else if (clk_en) begin
      if (restart_w) begin
        state_q   <= link_timing_pkg::ST_COMMA;
        link_up_q <= 1'b0;
      end else begin
        case (state_q)
          link_timing_pkg::ST_COMMA: begin
            if (lmfc_w) begin
              state_q    <= link_timing_pkg::ST_WAIT;
              pipe_cnt_q <= '0;
            end
          end
          link_timing_pkg::ST_WAIT: begin
            pipe_cnt_q <= pipe_cnt_q + 4'h1;
            if (pipe_done_w) begin
              state_q     <= link_timing_pkg::ST_ILA;
              mf_cnt_q    <= '0;
              ila_frame_q <= '0;
            end
          end
          link_timing_pkg::ST_ILA: begin
            ila_frame_q <= (ila_frame_q == k_q - 6'h01) ? 6'h00 : ila_frame_q + 6'h01;
            if (ila_frame_q == k_q - 6'h01) begin
              mf_cnt_q <= mf_cnt_q + 3'h1;
              if (mf_cnt_q == `ILA_MULTIFRAMES - 3'h1) begin
                state_q   <= link_timing_pkg::ST_DATA;
                link_up_q <= 1'b1;
              end
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Lane output
  // ****************************************************************
  wire in_ila_w   = (state_q == link_timing_pkg::ST_ILA);
  wire in_data_w  = (state_q == link_timing_pkg::ST_DATA);
  wire [15:0] fifo_data_w;
  wire        fifo_valid_w;
  // Middle frames carry a 10 prefix, so no frame index can ever
  // be mistaken for a start or end marker
  wire [7:0]  ila_mark_w = (ila_frame_q == 6'h00) ? `ILA_START :
                           (ila_frame_q == k_q - 6'h01) ? `ILA_END : {2'h2, ila_frame_q};

  assign fifo_pop_w = in_data_w;
  assign out_k_w    = !in_data_w;
  assign out_data_w = in_data_w ? fifo_data_w :
                      in_ila_w  ? {ila_mark_w, 5'h00, mf_cnt_q} : {`K28_5, `K28_5};

  sample_fifo #(.WIDTH(16), .DEPTH(`FIFO_DEPTH)) u_fifo (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .in_data   (sample_data),
    .in_valid  (sample_valid),
    .in_ready  (sample_ready),
    .out_data  (fifo_data_w),
    .out_valid (fifo_valid_w),
    .out_ready (fifo_pop_w)
  );

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lnk.lane_data  <= {`K28_5, `K28_5};
      lnk.lane_ctl_k <= 1'b1;
      lnk.lane_valid <= 1'b0;
    end else if (clk_en) begin
      lnk.lane_data  <= out_data_w;
      lnk.lane_ctl_k <= out_k_w;
      lnk.lane_valid <= !in_data_w || fifo_valid_w;
    end
  end
endmodule // link_tx_end

// ### rtl/link_rx_end.sv
// Purpose: Receiver end: drives SYSREF, SYNC and select with legal timing.
// Assumes: Same clock as the transmitter end.
// Notes:   Requests ignored until the pulse, hold or gap is complete.
`include "link_timing_defines.svh"

module link_rx_end (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  link_timing_if.rx        lnk,
  input  wire logic        sysref_req,
  input  wire logic        resync_req,
  input  wire logic        access_req,
  output logic             busy_q,
  output logic [15:0]      rx_data_q,
  output logic             rx_data_valid_q
);
  // ****************************************************************
  // SYSREF pulse shaping
  // ****************************************************************
  logic [2:0] sr_cnt_q;
  logic [2:0] sync_cnt_q;
  logic [2:0] gap_cnt_q;
  wire sr_idle_w   = (sr_cnt_q == 3'h0) && !lnk.sysref;
  wire sync_idle_w = (sync_cnt_q == 3'h0) && lnk.sync_n;
  wire gap_idle_w  = (gap_cnt_q == 3'h0) && lnk.spi_select_low;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lnk.sysref <= 1'b0;
      sr_cnt_q   <= '0;
    end else if (clk_en) begin
      if (sr_cnt_q != 3'h0) begin
        sr_cnt_q <= sr_cnt_q - 3'h1;
      end else if (lnk.sysref) begin
        lnk.sysref <= 1'b0;
        sr_cnt_q   <= `SYSREF_LOW_MIN - 3'h1;
      end else if (sysref_req) begin
        lnk.sysref <= 1'b1;
        sr_cnt_q   <= `SYSREF_HIGH_MIN - 3'h1;
      end
    end
  end

  // ****************************************************************
  // SYNC hold and select gap
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lnk.sync_n         <= 1'b0;
      sync_cnt_q         <= `SYNC_HOLD_MIN - 3'h1;
      lnk.spi_select_low <= 1'b1;
      gap_cnt_q          <= '0;
    end else if (clk_en) begin
      if (sync_cnt_q != 3'h0) begin
        sync_cnt_q <= sync_cnt_q - 3'h1;
      end else if (!lnk.sync_n) begin
        lnk.sync_n <= 1'b1;
      end else if (resync_req) begin
        lnk.sync_n <= 1'b0;
        sync_cnt_q <= `SYNC_HOLD_MIN - 3'h1;
      end
      if (gap_cnt_q != 3'h0) begin
        gap_cnt_q <= gap_cnt_q - 3'h1;
      end else if (!lnk.spi_select_low) begin
        lnk.spi_select_low <= 1'b1;
        gap_cnt_q          <= 3'(`GAP_CYCLES);
      end else if (access_req) begin
        lnk.spi_select_low <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Lane capture
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      busy_q          <= 1'b1;
      rx_data_q       <= '0;
      rx_data_valid_q <= 1'b0;
    end else if (clk_en) begin
      busy_q          <= !(sr_idle_w && sync_idle_w && gap_idle_w);
      rx_data_valid_q <= lnk.lane_valid && !lnk.lane_ctl_k;
      if (lnk.lane_valid && !lnk.lane_ctl_k) begin
        rx_data_q <= lnk.lane_data;
      end
    end
  end
endmodule // link_rx_end

// ### bench/link_timing_properties.sv
// Purpose: Concurrent checks on the wires between the two link ends.
// Assumes: One clock; synchronous active-high reset.
// Notes:   LMFC is not on the link, so its timing is left to the bench.
`include "link_timing_defines.svh"

module link_timing_properties (
  input wire logic                    clock,
  input wire logic                    sys_rst,
  input wire logic                    sysref,
  input wire logic                    sync_n,
  input wire link_timing_pkg::frame_t lane_data,
  input wire logic                    lane_ctl_k,
  input wire logic                    lane_valid,
  input wire logic                    spi_select_low
);
  // ********
  // Checks
  // ********
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire comma     = lane_ctl_k && lane_data == {`K28_5, `K28_5};
  wire ila_first = lane_data == {`ILA_START, 8'h00};
  wire ila_mark  = lane_data[15:8] == `ILA_START || lane_data[15:8] == `ILA_END;
  sequence s_two_high;
    sysref ##1 !sysref;
  endsequence
  sequence s_two_low;
    !sysref ##1 !sysref;
  endsequence
  // Bound covers a full 32-frame multiframe plus the output delay
  sequence s_ila_or_abort;
    ##[1:60] (ila_first || !sync_n);
  endsequence
  AST_SYSREF_HIGH: assert property ($rose(sysref) |=> s_two_high) else $error("sysref high time wrong");
  AST_SYSREF_LOW: assert property ($fell(sysref) |-> s_two_low) else $error("sysref low time short");
  AST_SYNC_HOLD: assert property ($fell(sync_n) |-> !sync_n [*4]) else $error("sync low hold short");
  AST_SELECT_GAP: assert property (!spi_select_low |=> spi_select_low) else $error("select gap missing");
  AST_COMMA_SYNC: assert property (!sync_n && !$past(sync_n) && !$past(sync_n, 2) |-> comma)
    else $error("no comma while sync low");
  AST_ILA_AFTER_SYNC: assert property ($rose(sync_n) |-> s_ila_or_abort)
    else $error("alignment did not start");
  AST_ILA_AFTER_COMMA: assert property ($rose(ila_first) |-> $past(comma))
    else $error("alignment not preceded by comma");
  AST_ILA_INDEX: assert property (ila_mark |-> lane_data[7:3] == 5'h00 && lane_data[2:0] <= 3'h3)
    else $error("alignment multiframe index out of range");
endmodule // link_timing_properties

// ### bench/testbench.sv
// Purpose: Self-checking bench joining both link ends.
// Assumes: clk_en high except for one five-cycle freeze; samples carry A5 in the upper byte.
// Notes:   Alignment delays are whole frames, rounded up from eighths.
`include "link_timing_defines.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  // ********
  // Signals
  // ********
  logic        clock, sys_rst, clk_en, gate, sysref_req, resync_req, access_req;
  logic        sample_valid, sample_ready, lmfc_pulse_q, aligned_q, link_up_q, busy_q, rx_data_valid_q;
  logic [1:0]  ratio;
  logic [5:0]  kfr;
  logic [15:0] sample_data, rx_data_q;
  int          bad_count, tests_run, cyc, fed, rx_n, last, t0, t1, t2, d0;
  // Divide code, requested frames, frames in effect after clamping, alignment delay in whole frames
  int          rows[4][4] = '{'{1, 9, 9, (`LMFC_DLY_DIV2_8TH + 7) / 8}, '{0, 8, 9, (`LMFC_DLY_DIV1_8TH + 7) / 8},
                              '{3, 40, 32, (`LMFC_DLY_DIV8_8TH + 7) / 8}, '{2, 32, 32, (`LMFC_DLY_DIV4_8TH + 7) / 8}};
  link_timing_if u_link_timing_if ();
  link_tx_end u_link_tx_end (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .lnk(u_link_timing_if.tx),
    .input_clock_divide_ratio(ratio), .frames_per_multiframe(kfr), .sysref_gate_en(gate),
    .sample_data(sample_data), .sample_valid(sample_valid), .sample_ready(sample_ready),
    .lmfc_pulse_q(lmfc_pulse_q), .aligned_q(aligned_q), .link_up_q(link_up_q));
  link_rx_end u_link_rx_end (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .lnk(u_link_timing_if.rx),
    .sysref_req(sysref_req), .resync_req(resync_req), .access_req(access_req), .busy_q(busy_q),
    .rx_data_q(rx_data_q), .rx_data_valid_q(rx_data_valid_q));
  link_timing_properties u_link_timing_properties (.clock(clock), .sys_rst(sys_rst),
    .sysref(u_link_timing_if.sysref), .sync_n(u_link_timing_if.sync_n), .lane_data(u_link_timing_if.lane_data),
    .lane_ctl_k(u_link_timing_if.lane_ctl_k), .lane_valid(u_link_timing_if.lane_valid),
    .spi_select_low(u_link_timing_if.spi_select_low));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // ********
  // Tasks
  // ********
  task automatic end_of_test();
    $display("Checks run %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  function automatic logic ev(input int w);
    case (w)
      0: ev = lmfc_pulse_q;
      1: ev = u_link_timing_if.lane_data == {`ILA_START, 8'h00};
      2: ev = u_link_timing_if.lane_valid && u_link_timing_if.lane_data[15:8] == 8'hA5;
      4: ev = aligned_q;
      default: ev = link_up_q;
    endcase
  endfunction
  task automatic wait_ev(input int w, output int t);
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (ev(w) !== 1'b1 && n < 300);
    t = cyc;
    check("event", ev(w), 1'b1);
  endtask
  function automatic logic taken(input int w);
    case (w)
      0: taken = u_link_timing_if.sysref;
      1: taken = !u_link_timing_if.sync_n;
      default: taken = !u_link_timing_if.spi_select_low;
    endcase
  endfunction
  // Busy requests are not queued: let an edge pass, wait for idle, then hold until taken
  task automatic req(input int w);
    int n;
    n = 0;
    @(negedge clock);
    while (busy_q !== 1'b0 && n < 100) begin
      @(negedge clock);
      n++;
    end
    case (w)
      0: sysref_req = 1'b1;
      1: resync_req = 1'b1;
      default: access_req = 1'b1;
    endcase
    do begin
      @(negedge clock);
      n++;
    end while (taken(w) !== 1'b1 && n < 200);
    t0 = cyc;
    {sysref_req, resync_req, access_req} = 3'h0;
    check("taken", taken(w), 1'b1);
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (sample_valid && sample_ready) fed <= fed + 1;
    if (lmfc_pulse_q === 1'b1) last <= cyc;
    if (rx_data_valid_q === 1'b1 && rx_n < 8) begin
      check("rx_data", {16'h0, rx_data_q}, 32'hA500 + rx_n);
      rx_n++;
    end
    if (cyc == 20000) begin
      bad_count++;
      end_of_test();
    end
  end
  always @(negedge clock) sample_data <= {8'hA5, fed[7:0]};
  // ********
  // Sequence
  // ********
  initial begin
    {sys_rst, clk_en, gate, ratio, kfr} = {1'b1, 1'b1, 1'b0, `DIV_1, `K_RESET};
    {sysref_req, resync_req, access_req, sample_valid, sample_data} = '0;
    repeat (6) @(negedge clock);
    sys_rst = 1'b0;
    sample_valid = 1'b1;
    repeat (12) @(negedge clock);
    check("fill", fed, `FIFO_DEPTH);
    check("full", sample_ready, 1'b0);
    wait_ev(3, t1);
    repeat (20) @(negedge clock);
    check("drained", rx_n, 8);
    foreach (rows[i]) begin
      @(negedge clock);
      ratio = 2'(rows[i][0]);
      kfr = 6'(rows[i][1]);
      gate = 1'b1;
      repeat (4) @(negedge clock);
      check("restart", link_up_q, 1'b0);
      req(0);
      wait_ev(4, t1);
      // One edge passes before the transmitter latches SYSREF
      d0 = t1 - t0 - 1;
      check("align", d0, rows[i][3]);
      check("align_rng", d0 >= 3 && d0 <= 4, 1'b1);
      wait_ev(0, t2);
      check("period", t2 - t1, rows[i][2]);
      check("aligned", aligned_q, 1'b1);
      req(1);
      repeat (6) @(negedge clock);
      wait_ev(1, t1);
      check("lmfc_ila", t1 - last >= 7 && t1 - last <= 9, 1'b1);
      wait_ev(2, t2);
      check("ila_len", t2 - t1, 4 * rows[i][2]);
      check("lmfc_data", t2 - last >= 7 && t2 - last <= 9, 1'b1);
      req(2);
      req(2);
    end
    gate = 1'b0;
    wait_ev(0, t1);
    repeat (3) @(negedge clock);
    req(0);
    wait_ev(0, t2);
    check("gated", t2 - t1, 32);
    // ********
    // Awkward cases
    // ********
    @(negedge clock);
    sample_valid = 1'b0;
    repeat (12) @(negedge clock);
    check("starved", u_link_timing_if.lane_valid, 1'b0);
    check("starved_rx", rx_data_valid_q, 1'b0);
    sample_valid = 1'b1;
    wait_ev(0, t1);
    @(negedge clock);
    clk_en = 1'b0;
    repeat (5) @(negedge clock);
    clk_en = 1'b1;
    wait_ev(0, t2);
    check("frozen", t2 - t1, 32 + 5);
    @(negedge clock);
    sys_rst = 1'b1;
    repeat (2) @(negedge clock);
    check("rst_link_up", link_up_q, 1'b0);
    check("rst_aligned", aligned_q, 1'b0);
    check("rst_busy", busy_q, 1'b1);
    check("rst_sync", u_link_timing_if.sync_n, 1'b0);
    check("rst_lane", {u_link_timing_if.lane_ctl_k, u_link_timing_if.lane_valid}, 2'h2);
    sys_rst = 1'b0;
    wait_ev(3, t1);
    end_of_test();
  end
endmodule // testbench
